// *** logic/spm_core.sv ***
// Setpoint comparison, output control and totalizing with APB registers.
// Assumes count_step is a one-cycle pulse and man_rst a synchronous level.
`timescale 1ns/1ps
module spm_core #(
    parameter int MS_CYCLES = spm_pkg::MS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_step,
    input wire logic man_rst,
    output logic out1,
    output logic out2
);
    logic [2:0] mode_r;
    logic down_r;
    logic [1:0] func_r;
    logic cfg_valid_r;
    logic [spm_pkg::CNT_W-1:0] sp1_r;
    logic [spm_pkg::CNT_W-1:0] sp2_r;
    logic [spm_pkg::PT_W-1:0] pt1_r;
    logic [spm_pkg::PT_W-1:0] pt2_r;
    logic [spm_pkg::CNT_W-1:0] count_r;
    logic [spm_pkg::CNT_W-1:0] total_r;
    logic out1_r;
    logic out2_r;
    logic halted_r;
    logic mr_prev_r;
    logic [31:0] div_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic tick;
    logic act;
    logic manual;
    logic tot_en;
    logic step;
    logic man_rise;
    logic [spm_pkg::CNT_W-1:0] cnt_step;
    logic [spm_pkg::CNT_W-1:0] term;
    logic [spm_pkg::CNT_W-1:0] start_val;
    logic hit1;
    logic hit2;
    logic auto_rel;
    logic hon2;
    logic t1_done;
    logic t2_done;
    logic rel2;
    logic t_clr;
    logic wr_en;
    logic setup;
    logic mapped;

    // APB slave: zero wait states, read data captured in the setup cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign mapped = (paddr == spm_pkg::A_CTRL) || (paddr == spm_pkg::A_SP1) ||
                    (paddr == spm_pkg::A_SP2) || (paddr == spm_pkg::A_PT1) ||
                    (paddr == spm_pkg::A_PT2) || (paddr == spm_pkg::A_COUNT) ||
                    (paddr == spm_pkg::A_TOTAL) || (paddr == spm_pkg::A_STAT);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !mapped;
            case (paddr)
                spm_pkg::A_CTRL: prdata_r <= {26'h0, func_r, down_r, mode_r};
                spm_pkg::A_SP1: prdata_r <= sp1_r;
                spm_pkg::A_SP2: prdata_r <= sp2_r;
                spm_pkg::A_PT1: prdata_r <= {16'h0, pt1_r};
                spm_pkg::A_PT2: prdata_r <= {16'h0, pt2_r};
                spm_pkg::A_COUNT: prdata_r <= count_r;
                spm_pkg::A_TOTAL: prdata_r <= total_r;
                spm_pkg::A_STAT: prdata_r <= {28'h0, cfg_valid_r, halted_r, out2_r, out1_r};
                default: prdata_r <= '0;
            endcase
        end
    end

    // Configuration registers; a code outside the defined modes disarms the outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_r <= spm_pkg::MODE_MR1;
            down_r <= 1'b0;
            func_r <= spm_pkg::FN_COUNTER;
            cfg_valid_r <= 1'b0;
            sp1_r <= '0;
            sp2_r <= '0;
            pt1_r <= '0;
            pt2_r <= '0;
        end else if (wr_en) begin
            case (paddr)
                spm_pkg::A_CTRL: begin
                    mode_r <= pwdata[spm_pkg::CTRL_MODE_LSB +: 3]; // R02
                    down_r <= pwdata[spm_pkg::CTRL_DIR_BIT]; // R07
                    func_r <= pwdata[spm_pkg::CTRL_FUNC_LSB +: 2];
                    cfg_valid_r <= (pwdata[spm_pkg::CTRL_MODE_LSB +: 3] <= spm_pkg::MODE_AR1); // R20
                end
                spm_pkg::A_SP1: sp1_r <= pwdata;
                spm_pkg::A_SP2: sp2_r <= pwdata;
                spm_pkg::A_PT1: pt1_r <= pwdata[spm_pkg::PT_W-1:0];
                spm_pkg::A_PT2: pt2_r <= pwdata[spm_pkg::PT_W-1:0];
                default: ;
            endcase
        end
    end

    // Millisecond tick for the pulse timers
    assign tick = (div_r == 32'(MS_CYCLES - 1)); // R19
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else if (tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Comparison on every count update
    assign act = cfg_valid_r && (func_r != spm_pkg::FN_TACH); // R01 R20
    assign manual = (mode_r != spm_pkg::MODE_AR1);
    assign tot_en = (func_r == spm_pkg::FN_COUNTER) || (func_r == spm_pkg::FN_TOTAL);
    assign step = act && count_step && !halted_r && !man_rst;
    assign man_rise = man_rst && !mr_prev_r;
    assign cnt_step = down_r ? count_r - 1'b1 : count_r + 1'b1;
    assign term = down_r ? '0 : sp2_r; // R07
    assign start_val = down_r ? sp2_r : '0;
    assign hit1 = step && (cnt_step == sp1_r); // R03 R19
    assign hit2 = step && (cnt_step == term); // R05 R06 R19
    assign auto_rel = (mode_r == spm_pkg::MODE_AR1) && (pt2_r != '0); // R18
    assign hon2 = (mode_r == spm_pkg::MODE_MR3) || (mode_r == spm_pkg::MODE_AR1); // R10
    assign rel2 = t2_done && out2_r; // R11
    assign t_clr = !act || man_rst;

    spm_pulse_timer u_t1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(hit1 && (pt1_r != '0)), // R04
        .clear(t_clr || (rel2 && !hit1)),
        .tick(tick),
        .len(pt1_r),
        .done(t1_done),
        .busy()
    );

    spm_pulse_timer u_t2 (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(hit2 && hon2 && (pt2_r != '0)), // R10 R11
        .clear(t_clr),
        .tick(tick),
        .len(pt2_r),
        .done(t2_done),
        .busy()
    );

    // Output one: set by first setpoint, cleared by its timer, manual reset or output two release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out1_r <= 1'b0;
        end else if (!act || man_rst) begin
            out1_r <= 1'b0; // R13
        end else if (hit1) begin
            out1_r <= 1'b1; // R03
        end else if (rel2) begin
            out1_r <= 1'b0; // R12 R13
        end else if (t1_done) begin
            out1_r <= 1'b0; // R04
        end
    end

    // Output two: set at the terminal value, released by an honoured pulse time or manual reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out2_r <= 1'b0;
        end else if (!act || man_rst) begin
            out2_r <= 1'b0;
        end else if (hit2) begin
            out2_r <= 1'b1; // R05 R06 R08 R09 R14 R15
        end else if (rel2) begin
            out2_r <= 1'b0; // R11
        end
    end

    // Count register with freeze, manual restart and automatic clear or reload
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_r <= '0; // R20
            halted_r <= 1'b0;
            mr_prev_r <= 1'b0;
        end else begin
            mr_prev_r <= man_rst;
            if (man_rst) begin
                count_r <= start_val;
                halted_r <= 1'b0; // R08 R09
            end else if (hit2 && auto_rel) begin
                count_r <= start_val; // R14 R15
            end else if (step) begin
                count_r <= cnt_step; // R05 R06 R10
                if (hit2 && (mode_r == spm_pkg::MODE_MR2)) begin
                    halted_r <= 1'b1; // R08 R09
                end
            end
        end
    end

    // Running total for counter and totalizer functions
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            total_r <= '0;
        end else if (act && tot_en && manual && man_rise) begin
            total_r <= total_r + count_r; // R16
        end else if (tot_en && hit2 && auto_rel) begin
            total_r <= total_r + cnt_step; // R17
        end
    end

    assign out1 = out1_r;
    assign out2 = out2_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_out1_hold: assert property ( // R03
        out1_r && (pt1_r == '0) && act && !man_rst && !rel2 && !t1_done |=> out1_r)
        else $error("output one dropped with zero pulse time");
    a_out1_timeout: assert property (t1_done && !hit1 |=> !out1_r) // R04
        else $error("output one still on after its pulse time");
    a_out2_terminal: assert property ( // R05
        hit2 && !man_rst |=> out2_r && (count_r == ($past(auto_rel) ? $past(start_val) : $past(cnt_step))))
        else $error("output two not set at terminal value");
    a_mr2_freeze: assert property ( // R08
        halted_r && !man_rst |=> $stable(count_r) && out2_r)
        else $error("count moved while frozen");
    a_auto_up: assert property (hit2 && auto_rel && !down_r |=> count_r == '0) // R14
        else $error("auto reset upcount did not clear count");
    a_auto_down: assert property (hit2 && auto_rel && down_r |=> count_r == $past(sp2_r)) // R15
        else $error("auto reset downcount did not reload");
    a_release_both: assert property (rel2 && !hit2 && !hit1 |=> !out2_r && !out1_r) // R12
        else $error("outputs not released together");
    a_total_manual: assert property ( // R16
        act && tot_en && manual && man_rise |=> total_r == $past(total_r) + $past(count_r))
        else $error("total missed manual reset add");
    a_no_autoreset: assert property ( // R18
        hit2 && (mode_r == spm_pkg::MODE_AR1) && (pt2_r == '0) |=> count_r == $past(cnt_step))
        else $error("auto reset with zero pulse time");
    a_idle_off: assert property (!act |=> !out1_r && !out2_r) // R01
        else $error("outputs active while disabled");

    c_auto_cycle: cover property (hit2 && auto_rel ##[1:1000] rel2);
    c_mr2_halt: cover property (hit2 && (mode_r == spm_pkg::MODE_MR2) ##[1:100] man_rst);
    c_out1_pulse: cover property (hit1 ##[1:1000] t1_done);
endmodule

// *** logic/spm_pulse_timer.sv ***
// Millisecond pulse timer used for the output pulse times.
// Assumes a one-cycle millisecond tick from the owner's divider.
`timescale 1ns/1ps
module spm_pulse_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic clear,
    input wire logic tick,
    input wire logic [spm_pkg::PT_W-1:0] len,
    output logic done,
    output logic busy
);
    logic [spm_pkg::PT_W-1:0] cnt_r;
    logic busy_r;

    assign busy = busy_r;
    assign done = busy_r && tick && !clear && !start && (cnt_r + 1'b1 == len); // R19

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end else if (clear) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r <= '0;
        end else if (done) begin
            busy_r <= 1'b0;
        end else if (busy_r && tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_timer_stops: assert property (done |=> !busy_r) // R19
        else $error("pulse timer still busy after expiry");
endmodule

// *** shared/spm_pkg.sv ***
// Constants for the setpoint and output-mode logic of a counter/timer.
// Assumes a 20 MHz system clock and an APB master with 32-bit data.
// Overview of operation
// R01 - Setpoint output logic works in every function except frequency/tachometer.
// R02 - Output-function code zero selects the first manual-reset mode.
// R03 - Output one turns on at first setpoint; zero pulse time holds it.
// R04 - Nonzero output-one pulse time turns output one off after that time.
// R05 - Mode one upcount: output two at second setpoint, count continues.
// R06 - Mode one downcount: output two at zero, count continues below.
// R07 - Direction bit one selects downcount; zero becomes terminal value.
// R08 - Mode two upcount: output two on, count frozen until manual reset.
// R09 - Mode two downcount: output two on, stop at zero until reset.
// R10 - Mode three: output two at terminal, counting continues, pulse honoured.
// R11 - Honoured nonzero output-two pulse time releases output two.
// R12 - Releasing output two by its timer also releases output one.
// R13 - Zero output-one time holds until manual reset or output two release.
// R14 - Auto-reset upcount: at second setpoint set output two, clear count.
// R15 - Auto-reset downcount: at zero set output two, reload second setpoint.
// R16 - Counter/totalizer manual modes add count to total on manual reset.
// R17 - Counter/totalizer auto mode adds count to total at each auto reset.
// R18 - Auto-reset needs nonzero output-two pulse time, else no auto reset.
// R19 - Compare on every count update; pulse times counted in millisecond ticks.
// R20 - Power-on clears count and timers; outputs off until valid code loaded.
package spm_pkg;
    localparam int CNT_W = 32;
    localparam int PT_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYC = CLK_HZ / 1000 * TICK_MS;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SP1 = 8'h04;
    localparam logic [7:0] A_SP2 = 8'h08;
    localparam logic [7:0] A_PT1 = 8'h0c;
    localparam logic [7:0] A_PT2 = 8'h10;
    localparam logic [7:0] A_COUNT = 8'h14;
    localparam logic [7:0] A_TOTAL = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_FUNC_LSB = 4;

    localparam logic [2:0] MODE_MR1 = 3'h0;
    localparam logic [2:0] MODE_MR2 = 3'h1;
    localparam logic [2:0] MODE_MR3 = 3'h2;
    localparam logic [2:0] MODE_AR1 = 3'h3;

    localparam logic [1:0] FN_COUNTER = 2'h0;
    localparam logic [1:0] FN_TOTAL = 2'h1;
    localparam logic [1:0] FN_TIMER = 2'h2;
    localparam logic [1:0] FN_TACH = 2'h3;
endpackage

// *** test/setpoint_output_mode_logic_tb.sv ***
// Self-checking bench for the setpoint and output-mode logic.
// Assumes zero-wait APB and a 4-cycle millisecond tick.
`timescale 1ns/1ps
module setpoint_output_mode_logic_tb;
    logic sys_clk, rst, psel, penable, pwrite, count_step, press, pready, pslverr, man_rst, out1, out2;
    logic [7:0] paddr, rises;
    logic [31:0] pwdata, prdata;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    spm_core #(.MS_CYCLES(4)) uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_step(count_step), .man_rst(man_rst), .out1(out1), .out2(out2));
    spm_far_side far (.sys_clk(sys_clk), .rst(rst), .press(press), .out1(out1), .out2(out2),
        .man_rst(man_rst), .rises(rises));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            end_of_test();
        end
    end
    task end_of_test;
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        bus(1'b1, a, wd, d, e);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        bus(1'b0, a, 32'h0, d, e);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task step(input int n);
        repeat (n) begin
            count_step <= 1'b1;
            @(posedge sys_clk);
        end
        count_step <= 1'b0;
        @(posedge sys_clk);
    endtask
    task outs(input logic e1, input logic e2);
        @(negedge sys_clk);
        chk("outputs", {30'h0, out2, out1}, {30'h0, e2, e1});
        @(posedge sys_clk);
    endtask
    task push;
        press <= 1'b1;
        @(posedge sys_clk);
        press <= 1'b0;
        cyc(4);
    endtask
    task restart;
        rst <= 1'b1;
        cyc(5);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    task setup(input logic [31:0] ctrl, input logic [31:0] pt1, input logic [31:0] pt2);
        restart();
        wr(spm_pkg::A_SP1, 32'h2);
        wr(spm_pkg::A_SP2, 32'h4);
        wr(spm_pkg::A_PT1, pt1);
        wr(spm_pkg::A_PT2, pt2);
        wr(spm_pkg::A_CTRL, ctrl);
    endtask
    task t_reset;
        logic [31:0] d;
        logic e;
        restart();
        rdc(spm_pkg::A_COUNT, 32'h0);
        rdc(spm_pkg::A_STAT, 32'h0);
        step(3);
        outs(1'b0, 1'b0);
        bus(1'b0, 8'h20, 32'h0, d, e);
        chk("unmapped", {d[30:0], e}, 32'h1);
    endtask
    task t_mr1;
        setup(32'h0, 32'h0, 32'h3);
        step(2);
        outs(1'b1, 1'b0);
        step(2);
        outs(1'b1, 1'b1);
        step(2);
        rdc(spm_pkg::A_COUNT, 32'h6);
        cyc(20);
        outs(1'b1, 1'b1);
        push();
        outs(1'b0, 1'b0);
        rdc(spm_pkg::A_TOTAL, 32'h6);
        chk("rises", {24'h0, rises}, 32'h2);
        setup(32'h8, 32'h0, 32'h3);
        push();
        rdc(spm_pkg::A_COUNT, 32'h4);
        step(4);
        outs(1'b1, 1'b1);
        step(1);
        rdc(spm_pkg::A_COUNT, 32'hffffffff);
    endtask
    task t_mr2;
        for (int dn = 0; dn < 2; dn++) begin
            setup(32'h1 | (dn << 3), 32'h0, 32'h3);
            push();
            step(6);
            rdc(spm_pkg::A_COUNT, dn ? 32'h0 : 32'h4);
            cyc(20);
            outs(1'b1, 1'b1);
            rdc(spm_pkg::A_STAT, 32'hf);
            push();
            step(1);
            rdc(spm_pkg::A_COUNT, dn ? 32'h3 : 32'h1);
        end
    endtask
    task t_mr3;
        setup(32'h2, 32'h0, 32'h2);
        step(4);
        outs(1'b1, 1'b1);
        cyc(12);
        outs(1'b0, 1'b0);
        step(1);
        rdc(spm_pkg::A_COUNT, 32'h5);
        setup(32'h2, 32'h3, 32'h0);
        step(2);
        outs(1'b1, 1'b0);
        cyc(16);
        outs(1'b0, 1'b0);
    endtask
    task t_auto;
        for (int dn = 0; dn < 2; dn++) begin
            setup(32'h3 | (dn << 3), 32'h0, 32'h2);
            push();
            step(4);
            rdc(spm_pkg::A_COUNT, dn ? 32'h4 : 32'h0);
            outs(1'b1, 1'b1);
        end
        setup(32'h3, 32'h0, 32'h2);
        step(4);
        rdc(spm_pkg::A_TOTAL, 32'h4);
        wr(spm_pkg::A_PT2, 32'h0);
        push();
        step(5);
        rdc(spm_pkg::A_COUNT, 32'h5);
    endtask
    task t_off;
        setup(32'h30, 32'h0, 32'h0);
        step(5);
        outs(1'b0, 1'b0);
        setup(32'h4, 32'h0, 32'h0);
        step(5);
        outs(1'b0, 1'b0);
        rdc(spm_pkg::A_CTRL, 32'h4);
        rdc(spm_pkg::A_STAT, 32'h0);
        setup(32'h20, 32'h0, 32'h0);
        step(3);
        outs(1'b1, 1'b0);
        push();
        rdc(spm_pkg::A_TOTAL, 32'h0);
        setup(32'h10, 32'h0, 32'h0);
        step(3);
        push();
        rdc(spm_pkg::A_TOTAL, 32'h3);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        count_step = 1'b0;
        press = 1'b0;
        t_reset();
        t_mr1();
        t_mr2();
        t_mr3();
        t_auto();
        t_off();
        end_of_test();
    end
endmodule

// *** test/spm_far_side.sv ***
// Far-side model: the manual reset switch and the two output loads.
// Assumes press is a one-cycle request raised just after a rising edge.
`timescale 1ns/1ps
module spm_far_side #(
    parameter int HOLD = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic press,
    input wire logic out1,
    input wire logic out2,
    output logic man_rst,
    output logic [7:0] rises
);
    int hold_r;
    logic out1_q;
    logic out2_q;
    // Switch stays closed for HOLD cycles so the count can restart after it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_r <= 0;
            man_rst <= 1'b0;
        end else begin
            hold_r <= press ? HOLD : (hold_r > 0 ? hold_r - 1 : 0);
            man_rst <= press || hold_r > 1;
        end
    end
    // Loads count every switch-on of either output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
            rises <= 8'h00;
        end else begin
            out1_q <= out1;
            out2_q <= out2;
            rises <= rises + 8'((out1 && !out1_q) + (out2 && !out2_q));
        end
    end
endmodule
